/* File: testbench/cmcr_config_regs_properties.sv */
`timescale 1ns/100ps
`default_nettype none
module cmcr_config_regs_props (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic resetn,
	input wire logic clk_en,
	// Register access
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_write,
	input wire logic reg_read,
	input wire logic [7:0] reg_rdata,
	// Status and outputs
	input wire logic pll_locked,
	input wire logic [31:0] user_ratio_value,
	input wire logic ratio_format_select,
	input wire logic missing_pulse_tolerance_en,
	input wire logic [1:0] reference_divider_select,
	input wire logic device_enabled,
	input wire logic clk_out,
	input wire logic clk_out_oe
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!resetn);
	logic hold_q, en2_q, run_q;
	logic [2:0] ulk_cnt;
	wire wr_ok = reg_write && clk_en;
	// Shadow of the hold, enable and run-on-unlock bits, frozen like the design when clk_en is low.
	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			hold_q <= 1'b0;
			en2_q <= 1'b0;
			run_q <= 1'b0;
			ulk_cnt <= 3'h0;
		end else if (clk_en) begin
			if (reg_write && reg_addr == 8'h05) begin
				hold_q <= reg_wdata[3];
				en2_q <= reg_wdata[0];
			end
			if (reg_write && reg_addr == 8'h17) begin
				run_q <= reg_wdata[4];
			end
			ulk_cnt <= pll_locked ? 3'h0 : ((ulk_cnt == 3'h7) ? ulk_cnt : ulk_cnt + 3'h1);
		end
	end
	// Register outputs follow the stored byte one edge later, hence two edges after the write.
	property p_ratio_msb; wr_ok && reg_addr == 8'h06 |-> ##2 user_ratio_value[31:24] == $past(reg_wdata, 2); endproperty
	a_ratio_msb: assert property (p_ratio_msb) else $error("ratio high byte");
	property p_skip; wr_ok && reg_addr == 8'h16 |-> ##2 missing_pulse_tolerance_en == $past(reg_wdata[7], 2); endproperty
	a_skip: assert property (p_skip) else $error("skip enable");
	property p_div; wr_ok && reg_addr == 8'h16 |-> ##2 reference_divider_select == $past(reg_wdata[4:3], 2); endproperty
	a_div: assert property (p_div) else $error("divider");
	property p_format; wr_ok && reg_addr == 8'h17 |-> ##2 ratio_format_select == $past(reg_wdata[3], 2); endproperty
	a_format: assert property (p_format) else $error("ratio format");
	property p_rsvd_read; reg_read && clk_en && reg_addr == 8'h04 |=> reg_rdata == 8'h00; endproperty
	a_rsvd_read: assert property (p_rsvd_read) else $error("reserved read");
	property p_unlock_low; ulk_cnt == 3'h7 && !run_q && !$past(run_q) |-> !clk_out; endproperty
	a_unlock_low: assert property (p_unlock_low) else $error("clock not held low");
	property p_held; hold_q && wr_ok && reg_addr == 8'h03 |-> ##2 $stable(device_enabled); endproperty
	a_held: assert property (p_held) else $error("held write applied");
	property p_direct; !hold_q && !$past(hold_q) && wr_ok && reg_addr == 8'h03 |-> ##2 device_enabled == ($past(reg_wdata[0], 2) && $past(en2_q)); endproperty
	a_direct: assert property (p_direct) else $error("write not applied");
	property p_en_both; device_enabled |-> en2_q || $past(en2_q); endproperty
	a_en_both: assert property (p_en_both) else $error("enabled without both bits");
endmodule // cmcr_config_regs_props
`default_nettype wire

/* File: testbench/cmcr_config_regs_tb.sv */
`timescale 1ns/100ps
`default_nettype none
module cmcr_config_regs_tb;
	logic sys_clk = 1'b0, resetn = 1'b0, clk_en = 1'b1;
	logic reg_write = 1'b0, reg_read = 1'b0, pll_locked = 1'b0;
	logic timing_reference_clock = 1'b1, freq_ref_in = 1'b0, pll_clk = 1'b1;
	logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
	logic [31:0] user_ratio_value;
	logic ratio_format_select, missing_pulse_tolerance_en, device_enabled;
	logic clk_out, clk_out_oe, aux_out, aux_oe;
	logic [1:0] reference_divider_select;
	logic [2:0] ratio_modifier_select;
	logic [7:0] ad [7] = '{8'h02, 8'h03, 8'h04, 8'h05, 8'h16, 8'h17, 8'h30};
	logic [7:0] mk [7] = '{8'h83, 8'hE7, 8'h00, 8'h09, 8'hD8, 8'h18, 8'h00};
	int fails = 0, checks = 0;
	int n;
	cmcr_config_regs i_dut (.*);
	always #12.5 sys_clk = ~sys_clk;
	// Reference at 10 MHz, a divide-by-one rate.
	always #50 timing_reference_clock = ~timing_reference_clock;
	task automatic check(input logic [31:0] s, input logic [31:0] e);
		checks++;
		if (s !== e) begin
			fails++;
			$display("ERROR %0t: saw %h want %h", $time, s, e);
		end
	endtask
	task automatic w(input int n);
		repeat (n) @(negedge sys_clk);
	endtask
	// A spare cycle after each access keeps strobes from being set twice in one step.
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		reg_addr = a;
		reg_wdata = d;
		reg_write = 1'b1;
		w(1);
		reg_write = 1'b0;
		w(1);
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		reg_addr = a;
		reg_read = 1'b1;
		w(1);
		reg_read = 1'b0;
		check(reg_rdata, e);
		w(1);
	endtask
	// The window is a whole number of divided periods, so the count is exact.
	task automatic rises(output int r);
		logic p;
		r = 0;
		w(2);
		p = aux_out;
		repeat (48) begin
			w(1);
			if (!p && aux_out) r++;
			p = aux_out;
		end
	endtask
	task automatic close_out;
		if (fails == 0 && checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	initial begin
		#2000000;
		fails++;
		close_out;
	end
	initial begin
		w(12);
		resetn = 1'b1;
		w(2);
		for (int i = 0; i < 7; i++) begin
			rd(ad[i], (i == 0) ? 8'h80 : 8'h00);
			wr(ad[i], 8'hFF);
			rd(ad[i], mk[i]);
			wr(ad[i], 8'h00);
		end
		for (int i = 0; i < 4; i++) wr(8'(8'h06 + i), 8'(8'h11 * (i + 1)));
		check(user_ratio_value, 32'h11223344);
		// The divider sweep ends on divide-by-one, which suits the reference rate.
		for (int i = 0; i < 3; i++) begin
			wr(8'h16, 8'(i * 8 + (i == 1) * 128));
			check(reference_divider_select, i);
			check(missing_pulse_tolerance_en, i == 1);
			rises(n);
			check(n, 3 << i);
		end
		wr(8'h17, 8'h08);
		w(1);
		check(clk_out, 0);
		check(ratio_format_select, 1);
		wr(8'h17, 8'h10);
		w(3);
		check(clk_out, 1);
		check(ratio_format_select, 0);
		// Lock config set to open drain must not disturb clock sources.
		wr(8'h16, 8'h50);
		for (int s = 0; s < 3; s++) begin
			wr(8'h03, 8'(s * 2));
			w(3);
			check(aux_oe, 1);
			if (s == 0) begin
				rises(n);
				check(n, 12);
			end else begin
				check(aux_out, s - 1);
			end
		end
		for (int c = 0; c < 2; c++) begin
			wr(8'h16, 8'(c * 64 + 16));
			wr(8'h03, 8'h06);
			for (int l = 0; l < 2; l++) begin
				pll_locked = l[0];
				w(4);
				check(aux_oe, !(c && l));
				if (!(c && l)) check(aux_out, !c && !l);
				rd(8'h02, l ? 8'h00 : 8'h80);
			end
		end
		wr(8'h03, 8'h01);
		check(device_enabled, 0);
		wr(8'h05, 8'h01);
		w(1);
		check(device_enabled, 1);
		wr(8'h05, 8'h09);
		wr(8'h03, 8'h00);
		wr(8'h02, 8'h01);
		w(1);
		check({device_enabled, clk_out_oe}, 2'h3);
		rd(8'h03, 8'h00);
		wr(8'h05, 8'h01);
		w(1);
		check({device_enabled, clk_out_oe}, 2'h0);
		// Enable bits set in the other order still start the device.
		wr(8'h03, 8'h01);
		check(device_enabled, 1);
		// A write while the clock enable is low must leave no trace.
		clk_en = 1'b0;
		wr(8'h03, 8'h00);
		clk_en = 1'b1;
		w(2);
		check(device_enabled, 1);
		close_out;
	end
endmodule // cmcr_config_regs_tb
bind cmcr_config_regs cmcr_config_regs_props i_props (.*);
`default_nettype wire

/* File: verilog/cmcr_aux_mux.v */
`timescale 1ns/100ps
`default_nettype none
`include "cmcr_regs.vh"
module cmcr_aux_mux (
	// Selection
	input wire [1:0] aux_source_select,
	input wire lock_indicator_config,
	input wire aux_disable,
	// Sources
	input wire ref_clk_div,
	input wire freq_ref_sync,
	input wire pll_clk_gated,
	input wire unlocked,
	// Pin
	output reg aux_out,
	output reg aux_oe
);
	always @* begin
		aux_out = 1'b0;
		aux_oe = 1'b1;
		// [RQ1] Source routing.
		case (aux_source_select)
			// [RQ11] Clocks skip lock config.
			`CMCR_SRC_REF: aux_out = ref_clk_div;
			`CMCR_SRC_IN: aux_out = freq_ref_sync;
			`CMCR_SRC_OUT: aux_out = pll_clk_gated;
			default: begin
				// [RQ2] Lock driver style.
				if (lock_indicator_config) begin
					// [RQ10] Open drain indication.
					aux_out = 1'b0;
					aux_oe = unlocked;
				end else begin
					// [RQ9] Push-pull indication.
					aux_out = unlocked;
				end
			end
		endcase
		// The disable bit floats the pin whatever the source.
		if (aux_disable) begin
			aux_oe = 1'b0;
		end
	end
endmodule // cmcr_aux_mux
`default_nettype wire

/* File: verilog/cmcr_config_regs.v */
// Function
// [RQ1] Aux source select: 00 ref clock, 01 freq input, 10 PLL output, 11 lock.
// [RQ2] Source 11 takes aux polarity and driver from lock indicator config.
// [RQ3] Normal control-port operation only when both enable bits are 1.
// [RQ4] Hold set: writes to 02h-04h are stored, applied after hold clears.
// [RQ5] Hold clear: control and configuration writes apply at once.
// [RQ6] Bytes 06h-09h form 32-bit ratio, most significant byte lowest address.
// [RQ7] Clock-skip bit 1 keeps lock despite missing reference pulses.
// [RQ8] Reference must stay below 80 kHz, gaps under 20 ms, for skipping.
// [RQ9] Lock config 0: push-pull, high when unlocked, low when locked.
// [RQ10] Lock config 1: open drain, low when unlocked, floating when locked.
// [RQ11] Lock config bit ignored when aux pin carries a clock.
// [RQ12] Divider field: 00 by four, 01 by two, 10 by one, 11 reserved.
// [RQ13] Software matches divider choice to reference frequency range.
// [RQ14] Output-on-unlock 0: clock outputs held low while unlocked.
// [RQ15] Output-on-unlock 1: clock outputs always run.
// [RQ16] Read-only status bit: 0 locked, 1 unlocked; drives aux indication.
// [RQ17] Format bit: 0 means 20.12 ratio, 1 means 12.20 ratio.
// [RQ18] Held writes all apply together in one cycle.
// [RQ19] Reserved bits stay zero and read as zero.
`timescale 1ns/100ps
`default_nettype none
`include "cmcr_regs.vh"
module cmcr_config_regs (
	// Clock and reset
	input wire sys_clk,
	input wire resetn,
	input wire clk_en,
	// Control port register access
	input wire [7:0] reg_addr,
	input wire [7:0] reg_wdata,
	input wire reg_write,
	input wire reg_read,
	output reg [7:0] reg_rdata,
	// Analog core status and clocks
	input wire pll_locked,
	input wire timing_reference_clock,
	input wire freq_ref_in,
	input wire pll_clk,
	// Configuration to the synthesizer
	output reg [31:0] user_ratio_value,
	output reg ratio_format_select,
	output reg missing_pulse_tolerance_en,
	output reg [1:0] reference_divider_select,
	output reg [2:0] ratio_modifier_select,
	output reg device_enabled,
	// Clock output pin
	output reg clk_out,
	output reg clk_out_oe,
	// Auxiliary pin
	output wire aux_out,
	output wire aux_oe
);
	// Shadow registers written by software.
	reg [7:0] dev_ctrl_w;
	reg [7:0] dev_cfg1_w;
	reg [7:0] dev_cfg2_w;
	// Registers in effect.
	reg [7:0] dev_ctrl_a;
	reg [7:0] dev_cfg1_a;
	reg [7:0] dev_cfg2_a;
	reg [7:0] global_configuration;
	reg [7:0] ratio_byte [0:3];
	reg [7:0] function_configuration_one;
	reg [7:0] function_configuration_two;
	// Synchronisers.
	reg lock_s1;
	reg lock_s2;
	reg fin_s1;
	reg fin_s2;
	reg ref_s1;
	reg ref_s2;
	reg ref_s3;
	reg pll_s1;
	reg pll_s2;
	reg [1:0] div_cnt;
	reg ref_div;
	wire unlocked;
	wire hold;
	wire [7:0] next_dev_ctrl;
	wire [7:0] next_dev_cfg1;
	wire [7:0] next_dev_cfg2;
	integer i;

	function [7:0] masked;
		input [7:0] value;
		input [7:0] mask;
		begin
			masked = value & mask;
		end
	endfunction

	function hit;
		input [7:0] addr;
		input [7:0] target;
		begin
			hit = reg_write && (addr == target);
		end
	endfunction

	// [RQ16] Unlock status bit.
	assign unlocked = ~lock_s2;
	assign hold = global_configuration[`CMCR_BIT_HOLD];
	// [RQ19] Reserved bits dropped.
	assign next_dev_ctrl = hit(reg_addr, `CMCR_ADDR_DEV_CTRL) ?
		masked(reg_wdata, `CMCR_MASK_DEV_CTRL) : dev_ctrl_w;
	assign next_dev_cfg1 = hit(reg_addr, `CMCR_ADDR_DEV_CFG1) ?
		masked(reg_wdata, `CMCR_MASK_DEV_CFG1) : dev_cfg1_w;
	assign next_dev_cfg2 = hit(reg_addr, `CMCR_ADDR_DEV_CFG2) ?
		masked(reg_wdata, `CMCR_MASK_DEV_CFG2) : dev_cfg2_w;

	// Pins come from other clocks, so each passes two flops first.
	always @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			lock_s1 <= 1'b0;
			lock_s2 <= 1'b0;
			fin_s1 <= 1'b0;
			fin_s2 <= 1'b0;
			ref_s1 <= 1'b0;
			ref_s2 <= 1'b0;
			pll_s1 <= 1'b0;
			pll_s2 <= 1'b0;
		end else if (clk_en) begin
			lock_s1 <= pll_locked;
			lock_s2 <= lock_s1;
			fin_s1 <= freq_ref_in;
			fin_s2 <= fin_s1;
			ref_s1 <= timing_reference_clock;
			ref_s2 <= ref_s1;
			pll_s1 <= pll_clk;
			pll_s2 <= pll_s1;
		end
	end

	always @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			dev_ctrl_w <= `CMCR_RESET_BYTE;
			dev_cfg1_w <= `CMCR_RESET_BYTE;
			dev_cfg2_w <= `CMCR_RESET_BYTE;
			dev_ctrl_a <= `CMCR_RESET_BYTE;
			dev_cfg1_a <= `CMCR_RESET_BYTE;
			dev_cfg2_a <= `CMCR_RESET_BYTE;
			global_configuration <= `CMCR_RESET_BYTE;
			function_configuration_one <= `CMCR_RESET_BYTE;
			function_configuration_two <= `CMCR_RESET_BYTE;
			for (i = 0; i < 4; i = i + 1) begin
				ratio_byte[i] <= `CMCR_RESET_BYTE;
			end
		end else if (clk_en) begin
			dev_ctrl_w <= next_dev_ctrl;
			dev_cfg1_w <= next_dev_cfg1;
			dev_cfg2_w <= next_dev_cfg2;
			// [RQ4] Hold defers 02h-04h.
			if (!hold) begin
				// [RQ5] Immediate effect.
				// [RQ18] Applied as one set.
				dev_ctrl_a <= next_dev_ctrl;
				dev_cfg1_a <= next_dev_cfg1;
				dev_cfg2_a <= next_dev_cfg2;
			end
			if (hit(reg_addr, `CMCR_ADDR_GLOBAL)) begin
				global_configuration <= masked(reg_wdata, `CMCR_MASK_GLOBAL);
			end
			if (hit(reg_addr, `CMCR_ADDR_FUNC1)) begin
				function_configuration_one <= masked(reg_wdata, `CMCR_MASK_FUNC1);
			end
			if (hit(reg_addr, `CMCR_ADDR_FUNC2)) begin
				function_configuration_two <= masked(reg_wdata, `CMCR_MASK_FUNC2);
			end
			for (i = 0; i < 4; i = i + 1) begin
				if (hit(reg_addr, `CMCR_ADDR_RATIO0 + i[7:0])) begin
					ratio_byte[i] <= reg_wdata;
				end
			end
		end
	end

	// Readback shows stored values, so software sees held writes too.
	always @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			reg_rdata <= 8'h00;
		end else if (clk_en && reg_read) begin
			case (reg_addr)
				`CMCR_ADDR_DEV_CTRL: reg_rdata <= {unlocked, dev_ctrl_w[6:0]};
				`CMCR_ADDR_DEV_CFG1: reg_rdata <= dev_cfg1_w;
				`CMCR_ADDR_DEV_CFG2: reg_rdata <= dev_cfg2_w;
				`CMCR_ADDR_GLOBAL: reg_rdata <= global_configuration;
				`CMCR_ADDR_RATIO0: reg_rdata <= ratio_byte[0];
				`CMCR_ADDR_RATIO1: reg_rdata <= ratio_byte[1];
				`CMCR_ADDR_RATIO2: reg_rdata <= ratio_byte[2];
				`CMCR_ADDR_RATIO3: reg_rdata <= ratio_byte[3];
				`CMCR_ADDR_FUNC1: reg_rdata <= function_configuration_one;
				`CMCR_ADDR_FUNC2: reg_rdata <= function_configuration_two;
				default: reg_rdata <= 8'h00;
			endcase
		end
	end

	// [RQ12] Reference divider.
	// Edges of the synchronised reference are counted, so it must stay below half the clock.
	always @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			ref_s3 <= 1'h0;
			div_cnt <= 2'h0;
			ref_div <= 1'h0;
		end else if (clk_en) begin
			ref_s3 <= ref_s2;
			if (ref_s2 && !ref_s3) begin
				div_cnt <= div_cnt + 2'h1;
			end
			case (reference_divider_select)
				2'h0: ref_div <= div_cnt[1];
				2'h1: ref_div <= div_cnt[0];
				default: ref_div <= ref_s2;
			endcase
		end
	end

	// Outputs registered from the applied configuration.
	always @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			user_ratio_value <= 32'h00000000;
			ratio_format_select <= 1'b0;
			missing_pulse_tolerance_en <= 1'b0;
			reference_divider_select <= 2'h0;
			ratio_modifier_select <= 3'h0;
			device_enabled <= 1'b0;
			clk_out <= 1'b0;
			clk_out_oe <= 1'b1;
		end else if (clk_en) begin
			// [RQ6] Big-endian ratio.
			user_ratio_value <= {ratio_byte[0], ratio_byte[1], ratio_byte[2], ratio_byte[3]};
			// [RQ17] Ratio format.
			ratio_format_select <= function_configuration_two[`CMCR_BIT_FORMAT];
			// [RQ7] Clock skip enable.
			missing_pulse_tolerance_en <= function_configuration_one[`CMCR_BIT_SKIP];
			reference_divider_select <=
				function_configuration_one[`CMCR_BIT_DIV_LO +: 2];
			ratio_modifier_select <= dev_cfg1_a[7:5];
			// [RQ3] Both enables required.
			device_enabled <= dev_cfg1_a[`CMCR_BIT_CFG_EN1] &
				global_configuration[`CMCR_BIT_CFG_EN2];
			// [RQ14] Low while unlocked.
			// [RQ15] Always running.
			clk_out <= (unlocked && !function_configuration_two[`CMCR_BIT_UNL_OUT]) ?
				1'b0 : pll_s2;
			clk_out_oe <= ~dev_ctrl_a[`CMCR_BIT_CLK_DIS];
		end
	end

	cmcr_aux_mux u_aux (
		.aux_source_select(dev_cfg1_a[`CMCR_BIT_SRC_LO +: 2]),
		.lock_indicator_config(function_configuration_one[`CMCR_BIT_LOCKCFG]),
		.aux_disable(dev_ctrl_a[`CMCR_BIT_AUX_DIS]),
		.ref_clk_div(ref_div),
		.freq_ref_sync(fin_s2),
		.pll_clk_gated(clk_out),
		.unlocked(unlocked),
		.aux_out(aux_out),
		.aux_oe(aux_oe)
	);
endmodule // cmcr_config_regs
`default_nettype wire

/* File: verilog/cmcr_regs.vh */
`ifndef CMCR_REGS_VH
`define CMCR_REGS_VH
// Register offsets on the control port.
`define CMCR_ADDR_DEV_CTRL 8'h02
`define CMCR_ADDR_DEV_CFG1 8'h03
`define CMCR_ADDR_DEV_CFG2 8'h04
`define CMCR_ADDR_GLOBAL 8'h05
`define CMCR_ADDR_RATIO0 8'h06
`define CMCR_ADDR_RATIO1 8'h07
`define CMCR_ADDR_RATIO2 8'h08
`define CMCR_ADDR_RATIO3 8'h09
`define CMCR_ADDR_FUNC1 8'h16
`define CMCR_ADDR_FUNC2 8'h17
// Writable bit masks; other bits are reserved and read zero, except the unlock status read in bit 7 of 02h.
`define CMCR_MASK_DEV_CTRL 8'h03
`define CMCR_MASK_DEV_CFG1 8'hE7
`define CMCR_MASK_DEV_CFG2 8'h00
`define CMCR_MASK_GLOBAL 8'h09
`define CMCR_MASK_FUNC1 8'hD8
`define CMCR_MASK_FUNC2 8'h18
// Field positions.
`define CMCR_BIT_UNLOCK 7
`define CMCR_BIT_AUX_DIS 1
`define CMCR_BIT_CLK_DIS 0
`define CMCR_BIT_CFG_EN1 0
`define CMCR_BIT_SRC_LO 1
`define CMCR_BIT_CFG_EN2 0
`define CMCR_BIT_HOLD 3
`define CMCR_BIT_SKIP 7
`define CMCR_BIT_LOCKCFG 6
`define CMCR_BIT_DIV_LO 3
`define CMCR_BIT_UNL_OUT 4
`define CMCR_BIT_FORMAT 3
// Reset value of every register.
`define CMCR_RESET_BYTE 8'h00
// Source select codes.
`define CMCR_SRC_REF 2'h0
`define CMCR_SRC_IN 2'h1
`define CMCR_SRC_OUT 2'h2
`define CMCR_SRC_LOCK 2'h3
`endif
